// file: design/autobaud_pkg.sv
// Constants and types shared by the autobaud detection unit
package autobaud_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] SER_OFS  = 8'h08;
  localparam logic [7:0] BAUD_OFS = 8'h0c;
  // Control register fields
  localparam int CTL_EN      = 0;
  localparam int CTL_AUTO_RX = 1;
  localparam int CTL_STIRQ   = 2;
  localparam int CTL_DNIRQ   = 3;
  localparam int CTL_FCSEL   = 4;
  localparam int CTL_ECHO    = 8;
  localparam int CTL_TX_FLIP = 10;
  localparam int CTL_RX_FLIP = 11;
  localparam logic [15:0] CTRL_MASK = 16'h0f1f;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  // Status register fields
  localparam int ST_FLOWER  = 0;
  localparam int ST_FUPPER  = 1;
  localparam int ST_SLOWER  = 2;
  localparam int ST_SUPPER  = 3;
  localparam int ST_WAIT    = 4;
  localparam logic [4:0] STAT_RST = 5'h00;
  // Serial control register fields
  localparam int SER_RUN  = 0;
  localparam int SER_RXON = 1;
  localparam int SER_ODD  = 2;
  localparam logic [2:0] SER_RST = 3'h0;
  // Echo select codes
  localparam logic [1:0] ECHO_OFF    = 2'h0;
  localparam logic [1:0] ECHO_DET    = 2'h1;
  localparam logic [1:0] ECHO_ALWAYS = 2'h2;
  // Frame characters, seven bit codes
  localparam logic [6:0] CHAR_LA = 7'h61;
  localparam logic [6:0] CHAR_UA = 7'h41;
  localparam logic [6:0] CHAR_LT = 7'h74;
  localparam logic [6:0] CHAR_UT = 7'h54;
  localparam int CASE_BIT  = 5;
  localparam int DATA_BITS = 8;
  localparam int MIN_PERIOD = 4;
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_FIRST  = 2'b01,
    PH_SECOND = 2'b11
  } phase_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rx_state_t;
endpackage

// file: design/autobaud_char_rx.sv
// Character receiver that measures the bit period on demand
`timescale 1ns/1ps
module autobaud_char_rx #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  input  wire logic             rx_i,
  input  wire logic             measure_i,
  input  wire logic [CNT_W-1:0] period_i,
  output wire logic             valid_o,
  output wire logic [7:0]       data_o,
  output wire logic [CNT_W-1:0] period_o
);
  import autobaud_pkg::*;

  rx_state_t        state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] per_reg, per_next;
  logic [7:0]       shift_reg, shift_next;
  logic [2:0]       bit_reg, bit_next;
  logic             valid_reg, valid_next;
  logic             prev_reg;

  wire tick = (cnt_reg == '0);
  wire fall = prev_reg & ~rx_i;
  wire [CNT_W-1:0] dec = cnt_reg - 1'b1;

  // Next state; measuring times the low start bit, the first data
  // bit of a first character, a or A, is a one so the rising edge ends it
  always_comb begin
    state_next = state_reg;
    cnt_next   = tick ? cnt_reg : dec;
    per_next   = per_reg;
    shift_next = shift_reg;
    bit_next   = bit_reg;
    valid_next = 1'b0;
    unique case (state_reg)
      RX_IDLE: begin
        if (fall) begin
          state_next = RX_START;
          per_next   = measure_i ? per_reg : period_i;
          cnt_next   = measure_i ? '0 : (period_i >> 1);
        end
      end
      RX_START: begin
        if (measure_i) begin
          cnt_next = cnt_reg + 1'b1;
          if (rx_i) begin
            // Glitches shorter than the least period are ignored
            state_next = (cnt_reg < CNT_W'(MIN_PERIOD)) ? RX_IDLE : RX_DATA;
            per_next   = cnt_reg + 1'b1; // Falling edge cycle counts too
            cnt_next   = cnt_reg >> 1;
            bit_next   = 3'h0;
          end
        end else if (tick) begin
          state_next = rx_i ? RX_IDLE : RX_DATA;
          cnt_next   = per_reg - 1'b1;
          bit_next   = 3'h0;
        end
      end
      RX_DATA: begin
        if (tick) begin
          shift_next = {rx_i, shift_reg[7:1]};
          cnt_next   = per_reg - 1'b1;
          bit_next   = bit_reg + 1'b1;
          if (bit_reg == 3'(DATA_BITS - 1)) state_next = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick) begin
          valid_next = rx_i;
          state_next = RX_IDLE;
        end
      end
    endcase
  end

  // Disabling the receiver drops any character in progress
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      state_reg <= RX_IDLE;
      cnt_reg   <= '0;
      per_reg   <= '0;
      shift_reg <= 8'h00;
      bit_reg   <= 3'h0;
      valid_reg <= 1'b0;
      prev_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      per_reg   <= per_next;
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      valid_reg <= valid_next;
      prev_reg  <= rx_i;
    end
  end

  assign valid_o  = valid_reg;
  assign data_o   = shift_reg;
  assign period_o = per_reg;
endmodule

// file: design/autobaud_detect.sv
// Autobaud detection unit with Wishbone register access
// Summary of operation
// - Control bit 0 starts detection; hardware clears it after the second stop bit.
// - Software clearing the enable aborts any detection in progress.
// - Auto receiver bit clears receiver enable at start, sets it on success.
// - Control bit 2 gates the start-of-detection interrupt.
// - Control bit 3 gates the detection-complete interrupt.
// - Control bit 4 adds an interrupt after the first character when control bit 3 is set.
// - Echo field bits 8-9 routes receive to transmit: off, detecting, always.
// - Control bit 10 inverts the transmit output.
// - Control bit 11 inverts the receive input before use.
// - Status bit 0 sets on a lower case a as first character.
// - Status bit 1 sets on an upper case A as first character.
// - Status bit 2 sets on a lower case t as second character.
// - Status bit 3 sets on an upper case T as second character.
// - Letter flags clear on enable or another letter; software may clear.
// - Waiting flag sets on enable, clears on first letter or software.
// - Second letter flag sets first, then enable clears and interrupt rises.
// - Nothing is received or sent unless the baud generator runs.
// - Parity odd selection is updated after a successful detection.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module autobaud_detect #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [31:0]      dat_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             we_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output wire logic [31:0]      dat_o,
  output wire logic             ack_o,
  input  wire logic             rxd_i,
  input  wire logic             tx_data_i,
  output wire logic             txd_o,
  output wire logic             rx_data_o,
  output wire logic             receiver_on_o,
  output wire logic             parity_odd_o,
  output wire logic             baud_gen_run_o,
  output wire logic [CNT_W-1:0] baud_value_o,
  output wire logic             baud_load_o,
  output wire logic             start_irq_o,
  output wire logic             detect_irq_request_o
);
  import autobaud_pkg::*;

  if (CNT_W < 4 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 4 and 32");
  end

  logic [15:0]      ctrl_reg, ctrl_next;
  logic [4:0]       stat_reg, stat_next;
  logic             run_reg, rxon_reg, odd_reg, odd_cap_reg;
  logic [CNT_W-1:0] baud_reg, meas_reg;
  phase_t           phase_reg, phase_next;
  logic             done_reg, ack_reg, txd_reg, rxd_reg;
  logic             start_irq_reg, det_irq_reg;
  logic [31:0]      dat_reg;
  logic             rx_meta_reg, rx_sync_reg;
  logic             ch_valid;
  logic [7:0]       ch_data;
  logic [CNT_W-1:0] ch_period;

  // Bus decode; one access per ack, the ack drops the cycle after
  wire wb_req   = cyc_i & stb_i & ~ack_reg;
  wire wb_wr    = wb_req & we_i;
  wire hit_ctrl = (adr_i == CTRL_OFS);
  wire hit_stat = (adr_i == STAT_OFS);
  wire hit_ser  = (adr_i == SER_OFS);
  wire hit_baud = (adr_i == BAUD_OFS);
  wire ctrl_wr  = wb_wr & hit_ctrl & (|sel_i[1:0]);
  wire stat_wr  = wb_wr & hit_stat & sel_i[0];
  wire ser_wr   = wb_wr & hit_ser & sel_i[0];

  // Byte lanes merge with the old value; reserved bits are masked
  wire [15:0] ctrl_wdata = {sel_i[1] ? dat_i[15:8] : ctrl_reg[15:8],
                            sel_i[0] ? dat_i[7:0]  : ctrl_reg[7:0]}
                           & CTRL_MASK;

  // Detection events
  wire en_now  = ctrl_reg[CTL_EN];
  wire start   = ctrl_wr & ctrl_wdata[CTL_EN] & ~en_now;
  wire abort   = ctrl_wr & ~ctrl_wdata[CTL_EN] & en_now;
  wire rx_in   = rx_sync_reg ^ ctrl_reg[CTL_RX_FLIP];
  wire rx_en   = run_reg & en_now & (phase_reg != PH_IDLE);
  wire is_low  = ch_data[CASE_BIT];
  wire is_a    = (ch_data[6:0] == CHAR_LA) | (ch_data[6:0] == CHAR_UA);
  wire is_t    = (ch_data[6:0] == CHAR_LT) | (ch_data[6:0] == CHAR_UT);
  wire first_hit  = ch_valid & (phase_reg == PH_FIRST) & is_a;
  wire second_val = ch_valid & (phase_reg == PH_SECOND);
  wire second_hit = second_val & is_t;
  wire [3:0] letter_set = {second_hit & ~is_low, second_hit & is_low,
                           first_hit & ~is_low, first_hit & is_low};
  wire [4:0] stat_clr = stat_wr ? ~dat_i[4:0] : 5'h00;
  wire [1:0] echo_sel = ctrl_reg[CTL_ECHO +: 2];
  wire echo_on = (echo_sel == ECHO_ALWAYS) |
                 ((echo_sel == ECHO_DET) & en_now);
  wire tx_src  = !run_reg ? 1'b1 : (echo_on ? rx_in : tx_data_i);

  autobaud_char_rx #(
    .CNT_W (CNT_W)
  ) u_char_rx (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (rx_en),
    .rx_i      (rx_in),
    .measure_i (phase_reg == PH_FIRST),
    .period_i  (meas_reg),
    .valid_o   (ch_valid),
    .data_o    (ch_data),
    .period_o  (ch_period)
  );

  // Control next value; the hardware clear of the enable comes one
  // cycle after the second letter flag so the flag is seen first
  always_comb begin
    ctrl_next = ctrl_wr ? ctrl_wdata : ctrl_reg;
    if (done_reg && !start) ctrl_next[CTL_EN] = 1'b0;
  end

  // Status next value; a hardware set always beats a software clear
  always_comb begin
    stat_next = stat_reg & ~stat_clr;
    if (start) begin
      stat_next = 5'h10;
    end else if (|letter_set) begin
      stat_next[3:0] = letter_set;
    end
    if (first_hit) stat_next[ST_WAIT] = 1'b0;
  end

  // Phase of the two character frame; a wrong second character
  // sends the search back to the first one
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_IDLE:   if (start) phase_next = PH_FIRST;
      PH_FIRST:  if (first_hit) phase_next = PH_SECOND;
      PH_SECOND: begin
        if (second_hit) phase_next = PH_IDLE;
        else if (second_val) phase_next = PH_FIRST;
      end
      default:   phase_next = PH_IDLE;
    endcase
    if (abort || (start && phase_reg != PH_IDLE)) begin
      phase_next = abort ? PH_IDLE : PH_FIRST;
    end
  end

  // Read data; reserved bits and unmapped addresses read zero
  wire [31:0] rdata = hit_ctrl ? 32'(ctrl_reg) :
                      hit_stat ? 32'(stat_reg) :
                      hit_ser  ? 32'({odd_reg, rxon_reg, run_reg}) :
                      hit_baud ? 32'(baud_reg) : 32'h00000000;

  // Pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rxd_i;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= wb_req;
      dat_reg <= wb_req ? rdata : 32'h00000000;
    end
  end

  // Detection state and registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= CTRL_RST;
      stat_reg  <= STAT_RST;
      phase_reg <= PH_IDLE;
      done_reg  <= 1'b0;
      meas_reg  <= '0;
    end else begin
      ctrl_reg  <= ctrl_next;
      stat_reg  <= stat_next;
      phase_reg <= phase_next;
      done_reg  <= second_hit;
      if (first_hit) meas_reg <= ch_period;
    end
  end

  // Serial control bits; the hardware updates come after a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {odd_reg, rxon_reg, run_reg} <= SER_RST;
      odd_cap_reg <= 1'b0;
      baud_reg    <= '0;
    end else begin
      if (ser_wr) begin
        {odd_reg, rxon_reg, run_reg} <= dat_i[2:0];
      end
      if (start && ctrl_wdata[CTL_AUTO_RX]) rxon_reg <= 1'b0;
      if (done_reg && ctrl_reg[CTL_AUTO_RX]) rxon_reg <= 1'b1;
      // Odd parity when the frame's eight bits carry an odd count
      if (first_hit) odd_cap_reg <= ^ch_data;
      if (done_reg) odd_reg <= odd_cap_reg;
      if (done_reg) baud_reg <= meas_reg;
    end
  end

  // Interrupt pulses and serial outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_irq_reg <= 1'b0;
      det_irq_reg   <= 1'b0;
      txd_reg       <= 1'b1;
      rxd_reg       <= 1'b1;
    end else begin
      start_irq_reg <= start & ctrl_wdata[CTL_STIRQ];
      det_irq_reg   <= ctrl_reg[CTL_DNIRQ] & (done_reg |
                       (ctrl_reg[CTL_FCSEL] & first_hit));
      txd_reg       <= tx_src ^ ctrl_reg[CTL_TX_FLIP];
      rxd_reg       <= rx_in & run_reg;
    end
  end

  assign dat_o                = dat_reg;
  assign ack_o                = ack_reg;
  assign txd_o                = txd_reg;
  assign rx_data_o            = rxd_reg;
  assign receiver_on_o        = rxon_reg;
  assign parity_odd_o         = odd_reg;
  assign baud_gen_run_o       = run_reg;
  assign baud_value_o         = baud_reg;
  assign baud_load_o          = done_reg;
  assign start_irq_o          = start_irq_reg;
  assign detect_irq_request_o = det_irq_reg;

  // Checks on the detection sequence
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_flag_first;
    (stat_reg[ST_SLOWER] | stat_reg[ST_SUPPER]) && !detect_irq_request_o;
  endsequence
  sequence s_irq_after;
    detect_irq_request_o == $past(ctrl_reg[CTL_DNIRQ]);
  endsequence

  property p_en_clear;
    done_reg && !start |=> !ctrl_reg[CTL_EN];
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("enable not cleared after detection");
  property p_abort;
    abort |=> phase_reg == PH_IDLE ##1 !u_char_rx.valid_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not stop detection");
  property p_rxon_off;
    start && ctrl_wdata[CTL_AUTO_RX] |=> !receiver_on_o;
  endproperty
  a_rxon_off: assert property (p_rxon_off)
    else $error("receiver not disabled at start");
  property p_rxon_on;
    done_reg && ctrl_reg[CTL_AUTO_RX] |=> receiver_on_o;
  endproperty
  a_rxon_on: assert property (p_rxon_on)
    else $error("receiver not enabled after detection");
  property p_start_irq;
    $rose(ctrl_reg[CTL_EN]) |-> start_irq_o == ctrl_reg[CTL_STIRQ];
  endproperty
  a_start_irq: assert property (p_start_irq)
    else $error("start interrupt wrong");
  property p_done_gate;
    detect_irq_request_o |-> $past(ctrl_reg[CTL_DNIRQ]);
  endproperty
  a_done_gate: assert property (p_done_gate)
    else $error("detect interrupt while disabled");
  property p_first_irq;
    first_hit |=> detect_irq_request_o ==
      $past(ctrl_reg[CTL_FCSEL] & ctrl_reg[CTL_DNIRQ]);
  endproperty
  a_first_irq: assert property (p_first_irq)
    else $error("first character interrupt wrong");
  property p_one_letter;
    $onehot0(stat_reg[3:0]);
  endproperty
  a_one_letter: assert property (p_one_letter)
    else $error("more than one letter flag set");
  property p_wait_start;
    start |=> stat_reg == 5'h10;
  endproperty
  a_wait_start: assert property (p_wait_start)
    else $error("status not reset at start");
  property p_order;
    second_hit |=> s_flag_first ##1 s_irq_after;
  endproperty
  a_order: assert property (p_order)
    else $error("second letter flag and interrupt out of order");
  property p_idle_tx;
    !run_reg |=> txd_o == !$past(ctrl_reg[CTL_TX_FLIP]);
  endproperty
  a_idle_tx: assert property (p_idle_tx)
    else $error("transmit not idle while stopped");
  property p_parity;
    done_reg |=> parity_odd_o == $past(odd_cap_reg) && baud_load_o == 1'b0;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity not updated after detection");
endmodule

// file: tb/serial_terminal.sv
// Remote serial terminal model that sends 8N1 characters
`timescale 1ns/1ps
module serial_terminal #(
  parameter int PERIOD = 16
) (
  input  wire logic       clk_i,
  input  wire logic       send_i,
  input  wire logic [7:0] char_i,
  input  wire logic       invert_i,
  input  wire logic       run_i,
  output wire logic       line_o,
  output logic            busy_o = 1'b0
);
  logic [9:0] frame   = 10'h3ff;
  int         bit_idx = 0;
  int         cnt     = 0;
  // Start bit low, data LSB first, stop bit high, line idles high
  always @(posedge clk_i) begin
    if (!busy_o) begin
      if (send_i && run_i) begin // Only while the generator runs
        frame <= {1'b1, char_i, 1'b0};
        busy_o <= 1'b1;
        cnt <= 0;
        bit_idx <= 0;
      end
    end else if (cnt == PERIOD - 1) begin
      cnt <= 0;
      if (bit_idx == 9) begin
        busy_o <= 1'b0;
        frame <= 10'h3ff;
      end else begin
        bit_idx <= bit_idx + 1;
        frame <= {1'b1, frame[9:1]};
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Inverted line lets the receive inverter be exercised
  assign line_o = frame[0] ^ invert_i;
endmodule

// file: tb/tb.sv
// Self-checking bench for the autobaud detection unit
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; \
  if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb;
  import autobaud_pkg::*;
  localparam int PER = 16;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] dat     = 32'h0;
  logic [3:0]  sel     = 4'h0;
  logic        we      = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        tx_data = 1'b0;
  logic        send    = 1'b0;
  logic [7:0]  ch      = 8'h00;
  logic        inv     = 1'b0;
  logic [31:0] rd;
  wire  [31:0] dat_o;
  wire         ack_o, txd_o, rx_data_o, recv_on, par_odd, run_o;
  wire  [15:0] baud_o;
  wire         load_o, start_o, det_o, line, busy;
  int fails = 0, samples_checked = 0, cycles = 0;
  int n_start = 0, n_det = 0, n_load = 0;

  autobaud_detect i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
    .dat_o(dat_o), .ack_o(ack_o), .rxd_i(line), .tx_data_i(tx_data),
    .txd_o(txd_o), .rx_data_o(rx_data_o), .receiver_on_o(recv_on),
    .parity_odd_o(par_odd), .baud_gen_run_o(run_o),
    .baud_value_o(baud_o), .baud_load_o(load_o), .start_irq_o(start_o),
    .detect_irq_request_o(det_o));
  serial_terminal #(.PERIOD(PER)) i_term (.clk_i(clk_i), .send_i(send),
    .char_i(ch), .invert_i(inv), .run_i(run_o), .line_o(line),
    .busy_o(busy));

  always #50 clk_i = ~clk_i;
  // Pulse counters and the hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (start_o === 1'b1) n_start++;
    if (det_o === 1'b1) n_det++;
    if (load_o === 1'b1) n_load++;
    if (cycles > 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic single Wishbone cycle; only the hang guard ends a stuck wait
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  // One character from the terminal, then time for recognition
  task automatic send_char(input logic [7:0] c);
    int n;
    n = 0;
    @(posedge clk_i);
    send <= 1'b1;
    ch <= c;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    tick(8);
  endtask

  task automatic t_reset();
    rdchk(CTRL_OFS, 32'h0, "ctrl reset");
    rdchk(STAT_OFS, 32'h0, "status reset");
    rdchk(8'h20, 32'h0, "unmapped read");
    wr(CTRL_OFS, 32'hf0e0);
    rdchk(CTRL_OFS, 32'h0, "ctrl reserved");
  endtask
  task automatic t_lower();
    wr(SER_OFS, 32'h3);
    `CHK("run", 1'b1, run_o)
    wr(CTRL_OFS, 32'h000f);
    tick(3);
    `CHK("start irq", 1, n_start)
    `CHK("receiver on", 1'b0, recv_on)
    rdchk(STAT_OFS, 32'h10, "waiting");
    send_char(8'h61);
    rdchk(STAT_OFS, 32'h01, "first lower");
    send_char(8'h74);
    `CHK("detect irq", 1, n_det)
    rdchk(STAT_OFS, 32'h04, "second lower");
    rdchk(CTRL_OFS, 32'h0e, "enable cleared");
    `CHK("receiver on", 1'b1, recv_on)
    `CHK("parity odd", 1'b1, par_odd)
    `CHK("baud value", 16'(PER), baud_o)
    `CHK("baud load", 1, n_load)
  endtask
  task automatic t_upper();
    wr(CTRL_OFS, 32'h0800);
    inv <= 1'b1;
    tick(4);
    wr(CTRL_OFS, 32'h0819);
    tick(3);
    `CHK("start irq off", 1, n_start)
    send_char(8'h41);
    `CHK("first char irq", 2, n_det)
    rdchk(STAT_OFS, 32'h02, "first upper");
    send_char(8'h54);
    `CHK("second irq", 3, n_det)
    rdchk(STAT_OFS, 32'h08, "second upper");
    `CHK("parity even", 1'b0, par_odd)
    wr(CTRL_OFS, 32'h0);
    inv <= 1'b0;
    tick(4);
  endtask
  task automatic t_abort();
    wr(CTRL_OFS, 32'h1);
    send_char(8'h61);
    rdchk(STAT_OFS, 32'h01, "first lower");
    wr(CTRL_OFS, 32'h0);
    send_char(8'h74);
    rdchk(STAT_OFS, 32'h01, "after abort");
    `CHK("no load", 2, n_load)
    wr(STAT_OFS, 32'h0);
    rdchk(STAT_OFS, 32'h0, "soft clear");
    wr(CTRL_OFS, 32'h1);
    send_char(8'h63);
    rdchk(STAT_OFS, 32'h10, "wrong first");
    send_char(8'h61);
    send_char(8'h74);
    `CHK("done irq off", 3, n_det)
    rdchk(STAT_OFS, 32'h04, "second lower");
  endtask
  // Echo codes against both transmit polarities; line idles high
  task automatic t_echo();
    int   c, v;
    logic e;
    for (c = 0; c < 4; c++) begin
      for (v = 0; v < 2; v++) begin
        tx_data <= c[0];
        wr(CTRL_OFS, (32'(c) << 8) | (32'(v) << 10));
        tick(6);
        e = ((c == 2) ? 1'b1 : tx_data) ^ v[0];
        `CHK("txd", e, txd_o)
        `CHK("rx data", 1'b1, rx_data_o)
      end
    end
    tx_data <= 1'b0;
    wr(CTRL_OFS, 32'h0101);
    tick(6);
    `CHK("echo detecting", 1'b1, txd_o)
    wr(CTRL_OFS, 32'h0);
    wr(SER_OFS, 32'h0);
    `CHK("run off", 1'b0, run_o)
    tick(6);
    `CHK("rx idle", 1'b0, rx_data_o)
    `CHK("txd idle", 1'b1, txd_o)
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_lower();
    t_upper();
    t_abort();
    t_echo();
    end_sim();
  end
endmodule
